// [include/hcsp_pkg.sv]
// Purpose: Shared constants and types of the high-frequency clock selector and prescaler
// Assumes: One 25 MHz system clock; oscillators arrive as sampled levels
// Notes:   Offsets are byte addresses on the plain register port

package hcsp_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int ADDR_W   = 8;            // Register address width
   localparam int DATA_W   = 32;           // Register data width
   localparam int PRESCALE_FIELD_W  = 8;            // Prescale field width
   localparam int NPRESC   = 6;            // Main, cpu, bus, periph a/b/c
   localparam int BUSEN_W  = 8;            // Gated main-domain modules
   localparam int NSRC     = 6;            // Selectable source count
   localparam int ACC_W    = 12;           // Peripheral access length width

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFS_SRC_SEL    = 8'h00;  // Source select
   localparam logic [7:0] OFS_SRC_STAT   = 8'h04;  // Source status
   localparam logic [7:0] OFS_PRESCALE_FIELD_BASE = 8'h08;  // Main prescaler, then cpu, bus, a, b, c
   localparam logic [7:0] OFS_BUS_EN     = 8'h20;  // Bus clock enables
   localparam logic [7:0] OFS_CTRL       = 8'h24;  // Automatic crystal start control
   localparam logic [7:0] OFS_OSC_EVT    = 8'h28;  // Slow oscillator ready events
   localparam logic [7:0] OFS_ACC_LEN    = 8'h2c;  // Peripheral access length

   // ****************************************
   // Field positions
   // ****************************************
   localparam int STAT_SRC_LSB   = 0;      // Source of the source clock
   localparam int STAT_MAIN_LSB  = 4;      // Source of the main clock
   localparam int STAT_DIV_BIT   = 8;      // Main clock is divided
   localparam int CTRL_AUTO_BIT  = 0;      // Auto crystal start enable
   localparam int EVT_SLOW_RC    = 0;      // Slow RC ready event
   localparam int EVT_SLOW_XTAL  = 1;      // Slow crystal ready event

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      SRC_FAST_RC      = 3'b000,
      SRC_FAST_RC_HALF = 3'b001,
      SRC_FAST_CRYSTAL = 3'b010,
      SRC_SLOW_RC      = 3'b011,
      SRC_SLOW_CRYSTAL = 3'b100,
      SRC_EXT_PIN      = 3'b101
   } hcsp_src_e;

   typedef enum logic [1:0] {
      ACTIVE_ENERGY_MODE     = 2'b00,
      SLEEP_ENERGY_MODE      = 2'b01,
      DEEP_SLEEP_ENERGY_MODE = 2'b10
   } hcsp_em_e;

   typedef struct packed {
      logic              wr;               // Write strobe
      logic              rd;               // Read strobe
      logic [ADDR_W-1:0] addr;             // Byte address
      logic [DATA_W-1:0] wdata;            // Write data
   } hcsp_bus_s;

   typedef struct packed {
      logic cpu;                           // Core domain tick
      logic bus;                           // Bus domain tick
      logic per_a;                         // Peripheral a tick
      logic per_b;                         // Peripheral b tick
      logic per_c;                         // Peripheral c tick
   } hcsp_dom_s;

   // ****************************************
   // Reset values and figures
   // ****************************************
   localparam hcsp_src_e RST_SRC = SRC_FAST_RC;
   localparam logic [PRESCALE_FIELD_W-1:0] RST_PRESCALE_FIELD  = 8'h00;
   localparam logic [BUSEN_W-1:0] RST_BUS_EN = 8'hff;
   localparam int SLOW_OSC_HZ       = 32768;
   localparam int ULTRA_SLOW_HZ     = 1000;
   localparam int AUX_MAX_HZ        = 48000000;
   localparam int MCLK_HZ           = 25000000;
   localparam int PERIPH_BASE_CYCLES = 3;

endpackage : hcsp_pkg

// [core/hcsp_srcsel.sv]
// Purpose: Source selection of the high-frequency source clock
// Assumes: Oscillator levels toggle no faster than half the system clock
// Notes:   Output is a one-cycle tick per selected source rising edge

`timescale 1ns/1ps

module hcsp_srcsel (
   input  wire logic                       mclk,      // System clock
   input  wire logic                       rst,       // Synchronous reset
   input  wire logic [hcsp_pkg::NSRC-1:0]  osc_lvl,   // Source levels
   input  wire hcsp_pkg::hcsp_src_e        sel,       // Selected source
   input  wire logic                       run,       // Not deep sleep
   output logic                            src_tick   // Source clock tick
);

   logic [hcsp_pkg::NSRC-1:0] lvl_q;      // Previous levels
   logic [hcsp_pkg::NSRC-1:0] rise;       // Rising edges
   logic                      sel_ok;     // Legal selection
   logic                      next_tick;  // Selected edge

   // ****************************************
   // Edge detect, one per source
   // ****************************************
   genvar i;
   generate
      for (i = 0; i < hcsp_pkg::NSRC; i++) begin : g_edge
         assign rise[i] = osc_lvl[i] & ~lvl_q[i];
      end
   endgenerate

   // Whole ticks only: a switch never yields a runt
   assign sel_ok    = (sel <= hcsp_pkg::SRC_EXT_PIN);
   assign next_tick = run & sel_ok & rise[sel];

   // Level history and registered tick
   always_ff @(posedge mclk) begin
      if (rst) begin
         lvl_q    <= '0;
         src_tick <= 1'b0;
      end else begin
         lvl_q    <= osc_lvl;
         src_tick <= next_tick;
      end
   end

endmodule : hcsp_srcsel

// [core/hcsp_prescale_field.sv]
// Purpose: Tick prescaler dividing an input tick stream by field plus one
// Assumes: Input ticks are one cycle long
// Notes:   A new factor acts at once; output stays whole ticks

`timescale 1ns/1ps

module hcsp_prescale_field (
   input  wire logic                         mclk,     // System clock
   input  wire logic                         rst,      // Synchronous reset
   input  wire logic                         in_tick,  // Input tick
   input  wire logic [hcsp_pkg::PRESCALE_FIELD_W-1:0] div,      // Prescale field
   output logic                              out_tick  // Divided tick
);

   logic [hcsp_pkg::PRESCALE_FIELD_W-1:0] cnt;     // Ticks since last output
   logic                         wrap;    // Terminal count reached

   // Greater-or-equal lets a smaller factor act immediately
   assign wrap = (cnt >= div);

   // Count input ticks, emit one every div+1
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt      <= '0;
         out_tick <= 1'b0;
      end else begin
         out_tick <= in_tick & wrap;
         if (in_tick) begin
            cnt <= wrap ? '0 : cnt + 8'h01;
         end
      end
   end

endmodule : hcsp_prescale_field

// [core/hcsp_top.sv]
// Purpose: High-frequency clock source selection, prescaling and gating
// Assumes: Clocks are modelled as one-cycle ticks in the mclk domain
// Notes:   Registers on a plain strobe port, read data one cycle later

`timescale 1ns/1ps

module hcsp_top (
   input  wire logic                          mclk,              // 25 MHz system clock
   input  wire logic                          rst,               // Synchronous reset
   input  wire hcsp_pkg::hcsp_bus_s           bus,               // Register port request
   output logic [hcsp_pkg::DATA_W-1:0]        rdata,             // Read data, cycle after read
   input  wire logic                          fast_rc_osc,       // Fast RC level
   input  wire logic                          fast_rc_osc_half,  // Fast RC halved level
   input  wire logic                          fast_crystal_osc,  // Fast crystal level
   input  wire logic                          slow_rc_osc,       // Slow RC level
   input  wire logic                          slow_crystal_osc,  // Slow crystal level
   input  wire logic                          ultra_slow_rc_osc, // Ultra-slow RC level
   input  wire logic                          ext_clock_pin,     // External clock pin level
   input  wire logic                          aux_fast_rc_osc,   // Asynchronous aux RC level
   input  wire logic                          fast_crystal_rdy,  // Fast crystal ready
   input  wire logic                          slow_rc_rdy,       // Slow RC ready
   input  wire logic                          slow_crystal_rdy,  // Slow crystal ready
   input  wire hcsp_pkg::hcsp_em_e            energy_mode,       // Current energy mode
   output logic                               hf_source_clock,   // Source clock tick
   output logic                               hf_main_clock,     // Main clock tick
   output hcsp_pkg::hcsp_dom_s                dom,               // Derived domain ticks
   output logic [hcsp_pkg::BUSEN_W-1:0]       module_clock,      // Gated main-domain ticks
   output logic                               ultra_slow_tick,   // Ultra-slow RC tick
   output logic                               aux_tick,          // Synchronised aux tick
   output logic                               wakeup_irq,        // Slow oscillator ready
   output logic [hcsp_pkg::ACC_W-1:0]         periph_access_len  // Core cycles per access
);

   // ****************************************
   // Registers and nets
   // ****************************************
   hcsp_pkg::hcsp_src_e             src_sel;          // Selected source
   logic [hcsp_pkg::PRESCALE_FIELD_W-1:0]    prescale_field [hcsp_pkg::NPRESC];  // Prescale fields
   logic [hcsp_pkg::BUSEN_W-1:0]    bus_en;           // Module clock enables
   logic                            auto_en;          // Auto crystal start enable
   logic [1:0]                      osc_evt;          // Sticky ready events
   logic                            xtal_rdy_q;       // Crystal ready history
   logic                            slow_rc_rdy_q;    // Slow RC ready history
   logic                            slow_xtal_rdy_q;  // Slow crystal ready history
   logic                            ultra_q;          // Ultra-slow history
   logic [2:0]                      aux_sync;         // Aux synchroniser chain
   logic [hcsp_pkg::NSRC-1:0]       osc_lvl;          // Levels in select order
   logic                            run;              // Source clock may run
   logic [hcsp_pkg::NPRESC-1:0]     tick;             // Prescaler outputs
   logic [hcsp_pkg::NPRESC-1:0]     tick_in;          // Prescaler inputs
   logic [hcsp_pkg::NPRESC-1:0]     prescale_field_wr;         // Prescaler write hits
   logic                            wr_sel;           // Select write hit
   logic                            wr_en;            // Enable write hit
   logic                            wr_ctrl;          // Control write hit
   logic                            wr_evt;           // Event clear hit
   logic                            sel_legal;        // Written code is a source
   logic                            auto_switch;      // Crystal became ready
   logic [1:0]                      evt_set;          // New ready events
   logic [hcsp_pkg::DATA_W-1:0]     stat_word;        // Status read value
   logic [hcsp_pkg::DATA_W-1:0]     next_rdata;       // Read mux
   logic [8:0]                      cpu_fac;          // Core factor
   logic [8:0]                      per_fac;          // Peripheral a factor
   logic [8:0]                      ratio;            // Core over peripheral
   logic [8:0]                      ratio_min1;       // Ratio at least one
   logic [hcsp_pkg::ACC_W-1:0]      next_acc;         // Lengthened access

   // ****************************************
   // Address decode
   // ****************************************
   assign wr_sel    = bus.wr & (bus.addr == hcsp_pkg::OFS_SRC_SEL);
   assign wr_en     = bus.wr & (bus.addr == hcsp_pkg::OFS_BUS_EN);
   assign wr_ctrl   = bus.wr & (bus.addr == hcsp_pkg::OFS_CTRL);
   assign wr_evt    = bus.wr & (bus.addr == hcsp_pkg::OFS_OSC_EVT);
   // Unknown source codes are dropped rather than stopping the clock
   assign sel_legal = (bus.wdata[2:0] <= 3'h5);

   // ****************************************
   // Source selection
   // ****************************************
   // Crystal ready edge while auto start is armed
   assign auto_switch = auto_en & fast_crystal_rdy & ~xtal_rdy_q;

   // Hardware switch beats a software write in the same cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         src_sel <= hcsp_pkg::RST_SRC;
      end else if (auto_switch) begin
         src_sel <= hcsp_pkg::SRC_FAST_CRYSTAL;
      end else if (wr_sel && sel_legal) begin
         src_sel <= hcsp_pkg::hcsp_src_e'(bus.wdata[2:0]);
      end
   end

   // Levels ordered by source code
   assign osc_lvl = {ext_clock_pin, slow_crystal_osc, slow_rc_osc,
                     fast_crystal_osc, fast_rc_osc_half, fast_rc_osc};
   // Stopped in deep sleep, free in active and sleep
   assign run = (energy_mode != hcsp_pkg::DEEP_SLEEP_ENERGY_MODE);

   hcsp_srcsel u_srcsel (
      .mclk     (mclk),
      .rst      (rst),
      .osc_lvl  (osc_lvl),
      .sel      (src_sel),
      .run      (run),
      .src_tick (hf_source_clock)
   );

   // ****************************************
   // Prescaler chain
   // ****************************************
   // Entry 0 is the main clock; all others hang off it
   genvar i;
   generate
      for (i = 0; i < hcsp_pkg::NPRESC; i++) begin : g_prescale_field
         assign prescale_field_wr[i] = bus.wr &
            (bus.addr == hcsp_pkg::OFS_PRESCALE_FIELD_BASE + 8'(4 * i));
         assign tick_in[i]  = (i == 0) ? hf_source_clock : tick[0];

         // Fields take effect the cycle after the write
         always_ff @(posedge mclk) begin
            if (rst) begin
               prescale_field[i] <= hcsp_pkg::RST_PRESCALE_FIELD;
            end else if (prescale_field_wr[i]) begin
               prescale_field[i] <= bus.wdata[hcsp_pkg::PRESCALE_FIELD_W-1:0];
            end
         end

         hcsp_prescale_field u_prescale_field (
            .mclk     (mclk),
            .rst      (rst),
            .in_tick  (tick_in[i]),
            .div      (prescale_field[i]),
            .out_tick (tick[i])
         );
      end
   endgenerate

   assign hf_main_clock = tick[0];
   assign dom.cpu       = tick[1];
   assign dom.bus       = tick[2];
   assign dom.per_a     = tick[3];
   assign dom.per_b     = tick[4];
   assign dom.per_c     = tick[5];

   // ****************************************
   // Module clock gating
   // ****************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         bus_en <= hcsp_pkg::RST_BUS_EN;
      end else if (wr_en) begin
         bus_en <= bus.wdata[hcsp_pkg::BUSEN_W-1:0];
      end
   end

   // A cleared bit blocks every tick, no partial pulses
   assign module_clock = {hcsp_pkg::BUSEN_W{hf_main_clock}} & bus_en;

   // ****************************************
   // Peripheral access lengthening
   // ****************************************
   assign cpu_fac    = {1'b0, prescale_field[1]} + 9'h001;
   assign per_fac    = {1'b0, prescale_field[3]} + 9'h001;
   // Bigger factor means slower clock, so this is periph speed over core
   assign ratio      = cpu_fac / per_fac;
   assign ratio_min1 = (ratio == 9'h000) ? 9'h001 : ratio;
   // Widened before the product: a ratio of 256 times three needs ten bits
   assign next_acc   = {3'h0, ratio_min1} * 12'(hcsp_pkg::PERIPH_BASE_CYCLES);

   always_ff @(posedge mclk) begin
      if (rst) begin
         periph_access_len <= 12'(hcsp_pkg::PERIPH_BASE_CYCLES);
      end else begin
         periph_access_len <= next_acc;
      end
   end

   // ****************************************
   // Slow oscillators and wakeup
   // ****************************************
   assign evt_set = {slow_crystal_rdy & ~slow_xtal_rdy_q,
                     slow_rc_rdy & ~slow_rc_rdy_q};

   // Set beats a write-one clear in the same cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         osc_evt         <= 2'h0;
         slow_rc_rdy_q   <= 1'b0;
         slow_xtal_rdy_q <= 1'b0;
         xtal_rdy_q      <= 1'b0;
         auto_en         <= 1'b0;
      end else begin
         osc_evt         <= evt_set | (osc_evt & ~({2{wr_evt}} & bus.wdata[1:0]));
         slow_rc_rdy_q   <= slow_rc_rdy;
         slow_xtal_rdy_q <= slow_crystal_rdy;
         xtal_rdy_q      <= fast_crystal_rdy;
         if (wr_ctrl) begin
            auto_en <= bus.wdata[hcsp_pkg::CTRL_AUTO_BIT];
         end
      end
   end

   // Level wakeup so deep sleep can wait for startup
   assign wakeup_irq = |osc_evt;

   // ****************************************
   // Ultra-slow and auxiliary clocks
   // ****************************************
   // Aux runs unrelated to mclk, so two flops before any use
   always_ff @(posedge mclk) begin
      if (rst) begin
         aux_sync        <= 3'h0;
         ultra_q         <= 1'b0;
         aux_tick        <= 1'b0;
         ultra_slow_tick <= 1'b0;
      end else begin
         aux_sync        <= {aux_sync[1:0], aux_fast_rc_osc};
         ultra_q         <= ultra_slow_rc_osc;
         aux_tick        <= aux_sync[1] & ~aux_sync[2];
         ultra_slow_tick <= ultra_slow_rc_osc & ~ultra_q;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   assign stat_word = (32'(src_sel) << hcsp_pkg::STAT_SRC_LSB) |
                      (32'(src_sel) << hcsp_pkg::STAT_MAIN_LSB) |
                      (32'(prescale_field[0] != 8'h00) << hcsp_pkg::STAT_DIV_BIT);

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (bus.rd) begin
         for (int k = 0; k < hcsp_pkg::NPRESC; k++) begin
            if (bus.addr == hcsp_pkg::OFS_PRESCALE_FIELD_BASE + 8'(4 * k)) begin
               next_rdata = 32'(prescale_field[k]);
            end
         end
         case (bus.addr)
            hcsp_pkg::OFS_SRC_SEL:  next_rdata = 32'(src_sel);
            hcsp_pkg::OFS_SRC_STAT: next_rdata = stat_word;
            hcsp_pkg::OFS_BUS_EN:   next_rdata = 32'(bus_en);
            hcsp_pkg::OFS_CTRL:     next_rdata = 32'(auto_en);
            hcsp_pkg::OFS_OSC_EVT:  next_rdata = 32'(osc_evt);
            hcsp_pkg::OFS_ACC_LEN:  next_rdata = 32'(periph_access_len);
            default:                next_rdata = next_rdata;
         endcase
      end
   end

   // Data only in the cycle after the read, zero otherwise
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= next_rdata;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   reset_source_a: assert property (@(posedge mclk) $past(rst) |-> src_sel == hcsp_pkg::SRC_FAST_RC)
      else $error("source not fast RC after reset");
   sel_write_a: assert property (@(posedge mclk) disable iff (rst)
      wr_sel && sel_legal && !auto_switch |=> src_sel == $past(bus.wdata[2:0]))
      else $error("source select write not applied");
   auto_xtal_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(fast_crystal_rdy) && auto_en |=> src_sel == hcsp_pkg::SRC_FAST_CRYSTAL)
      else $error("auto start did not select crystal");
   status_read_a: assert property (@(posedge mclk) disable iff (rst)
      bus.rd && bus.addr == hcsp_pkg::OFS_SRC_STAT |=> rdata[2:0] == $past(src_sel))
      else $error("status does not show source");
   deep_stop_a: assert property (@(posedge mclk) disable iff (rst)
      energy_mode == hcsp_pkg::DEEP_SLEEP_ENERGY_MODE [*2] |-> !hf_source_clock)
      else $error("source clock runs in deep sleep");
   undivided_a: assert property (@(posedge mclk) disable iff (rst)
      hf_source_clock && prescale_field[0] == 8'h00 |=> hf_main_clock)
      else $error("zero prescale divided the clock");
   gate_off_a: assert property (@(posedge mclk) disable iff (rst)
      !bus_en[0] |-> !module_clock[0])
      else $error("gated module clock ticked");
   spacing_a: assert property (@(posedge mclk) disable iff (rst)
      hf_main_clock && prescale_field[0] == 8'h01 && $stable(prescale_field[0]) |=> !hf_main_clock [*3])
      else $error("divide by two ticked too soon");
   wakeup_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(slow_rc_rdy) |-> ##[1:2] wakeup_irq)
      else $error("no wakeup after slow oscillator ready");

endmodule : hcsp_top

// [test/hcsp_top_bench.sv]
// Purpose: Self-checking bench of the clock selector and prescaler
// Assumes: Plain strobe register port, read data one cycle later
// Notes:   Oscillators are slow levels, at least two mclk per phase
`timescale 1ns/1ps
module hcsp_top_bench;
   // ****************************************
   // Stimulus, taps and counters
   // ****************************************
   typedef struct {logic [7:0] a; logic [31:0] d, e;} hcsp_row_s;  // Write, then expected readback
   logic                mclk = 0, rst = 1;                         // Clock and reset
   hcsp_pkg::hcsp_bus_s bus = '0;                                  // Register port
   hcsp_pkg::hcsp_em_e  em = hcsp_pkg::ACTIVE_ENERGY_MODE;         // Energy mode
   logic [7:0]          osc = '0;                                  // Oscillator levels
   logic [2:0]          rdy = '0;                                  // Ready levels
   logic [31:0]         rdata;                                     // Read data
   logic                src, main_t, irq;                          // Watched ticks and wakeup
   logic [7:0]          mod;                                       // Gated module ticks
   int                  n_fail = 0, n_checks = 0, ns = 0, nm = 0, nmod = 0, s0, m0, d0;
   int                  nd = 0, nu = 0, na = 0;                    // Cpu, ultra-slow and aux tallies
   hcsp_pkg::hcsp_dom_s dom;                                       // Derived domain ticks
   logic                ult, aux;                                  // Ultra-slow and aux ticks
   // Select 6 is out of range and must leave 5 in place
   hcsp_row_s rows[5] = '{'{8'h00,5,5}, '{8'h00,6,5}, '{8'h08,3,3}, '{8'h30,7,0}, '{8'h2c,9,3}};
   always #20 mclk = ~mclk;                                        // 25 MHz
   always @(posedge mclk) begin                                    // Tick tallies
      ns += src;
      nm += main_t;
      nmod += mod[0];
      nd += dom.cpu;
      nu += ult;
      na += aux;
   end
   hcsp_top hcsp_top_inst (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .fast_rc_osc(osc[0]),
      .fast_rc_osc_half(osc[1]), .fast_crystal_osc(osc[2]), .slow_rc_osc(osc[3]), .slow_crystal_osc(osc[4]),
      .ultra_slow_rc_osc(osc[5]), .ext_clock_pin(osc[6]), .aux_fast_rc_osc(osc[7]), .fast_crystal_rdy(rdy[0]),
      .slow_rc_rdy(rdy[1]), .slow_crystal_rdy(rdy[2]), .energy_mode(em), .hf_source_clock(src),
      .hf_main_clock(main_t), .dom(dom), .module_clock(mod), .ultra_slow_tick(ult), .aux_tick(aux),
      .wakeup_irq(irq), .periph_access_len());
   // ****************************************
   // Tasks
   // ****************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin                                       // Mismatch
         n_fail++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk) bus <= '{1'b1, 1'b0, a, d};
      @(posedge mclk) bus <= '0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk) bus <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge mclk) bus <= '0;
      @(negedge mclk) chk(rdata, e);                               // Data stand only this cycle
   endtask : rd
   task edges(input int n);                                        // Rising edges of the fast RC level
      repeat (n) begin
         osc[0] <= 1'b1;
         repeat (2) @(posedge mclk);
         osc[0] <= 1'b0;
         repeat (2) @(posedge mclk);
      end
      repeat (4) @(posedge mclk);                                  // Let the tick pipeline drain
   endtask : edges
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop
   // ****************************************
   // Sequence and watchdog
   // ****************************************
   initial begin
      #200us;                                                      // Tests need a few hundred cycles
      n_fail++;
      report_and_stop;
   end
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      rd(8'h00, 0);
      rd(8'h20, 32'hff);
      $display("reset done");
      foreach (rows[i]) begin                                      // Ordinary register cases
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      for (int s = 0; s < 6; s++) begin                            // Every source code
         wr(8'h00, s);                                             // Only status is read meanwhile
         rd(8'h04, 32'h100 | (s << 4) | s);
      end
      $display("register table done");
      wr(8'h00, 0);                                                // Fast RC back first
      wr(8'h20, 32'hfe);
      s0 = ns; m0 = nm; d0 = nmod;
      edges(8);
      chk(ns - s0, 8);
      chk(nm - m0, 2);
      chk(nmod - d0, 0);
      em <= hcsp_pkg::DEEP_SLEEP_ENERGY_MODE;
      s0 = ns;
      edges(4);
      chk(ns - s0, 0);
      em <= hcsp_pkg::ACTIVE_ENERGY_MODE;
      wr(8'h08, 0);
      m0 = nm;
      d0 = nd;
      edges(2);
      chk(nm - m0, 2);
      chk(nd - d0, 2);
      wr(8'h08, 1);
      m0 = nm;
      edges(4);
      chk(nm - m0, 2);
      osc[5] <= 1'b1;
      osc[7] <= 1'b1;
      repeat (6) @(posedge mclk);
      chk(nu, 1);
      chk(na, 1);
      $display("clock path done");
      rdy[1] <= 1'b1;
      repeat (2) @(posedge mclk);
      @(negedge mclk) chk(irq, 1);
      wr(8'h28, 1);
      @(negedge mclk) chk(irq, 0);
      wr(8'h24, 1);
      rdy[0] <= 1'b1;
      rd(8'h00, 2);
      wr(8'h0c, 2);
      wr(8'h14, 0);
      rd(8'h2c, 9);
      $display("events and access length done");
      @(posedge mclk) rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rd(8'h00, 0);
      rd(8'h08, 0);
      rd(8'h04, 0);
      $display("mid-run reset done");
      report_and_stop;
   end
endmodule : hcsp_top_bench
